// >>> rtl/serial_port_top.sv
`timescale 1ns/1ps
`default_nettype none

module serial_port_top
	import serial_port_pkg::*;
(
	// Clock and resets
	input  wire logic                        I_SYS_CLK,
	input  wire logic                        I_RST,
	input  wire logic                        I_DEV_RESET_N,
	// Serial link
	input  wire logic                        I_SCLK,
	input  wire logic                        I_SYNC_N,
	input  wire logic                        I_SDI,
	output logic                             O_SDO,
	output logic                             O_SDO_OE,
	// Word to send in the next frame
	input  wire logic [WORD_W-1:0]           I_TX_DATA,
	output logic                             O_TX_TAKEN,
	// DAC words received
	output logic      [WORD_W-1:0]           O_RX_DATA,
	output logic                             O_RX_VALID,
	input  wire logic                        I_RX_READY,
	output logic                             O_RX_DROP,
	// Converter status
	input  wire logic                        I_ADC_BUSY,
	// Configurable pins
	input  wire logic [PIN_COUNT-1:0]        I_PIN_IN,
	output logic      [PIN_COUNT-1:0]        O_PIN_OUT,
	output logic      [PIN_COUNT-1:0]        O_PIN_OE,
	output logic      [PIN_COUNT*ROLE_W-1:0] O_PIN_ROLE,
	output logic      [PIN_COUNT-1:0]        O_GPIO_IN
);
	typedef struct packed {
		logic                        sclk_s1;
		logic                        sclk_s2;
		logic                        sclk_s3;
		logic                        sync_s1;
		logic                        sync_s2;
		logic                        sync_s3;
		logic                        sdi_s1;
		logic                        sdi_s2;
		logic [PIN_COUNT-1:0]        pin_s1;
		logic [PIN_COUNT-1:0]        pin_s2;
		frame_state_e                fstate;
		logic [3:0]                  bit_idx;
		logic                        fell;
		logic [WORD_W-1:0]           rx_shift;
		logic [WORD_W-1:0]           tx_shift;
		logic                        serial_output;
		logic                        sdo_oe;
		logic                        tx_taken;
		logic                        push_req;
		logic [WORD_W-1:0]           push_data;
		logic                        drop;
		logic [WORD_W-1:0]           rx_data;
		logic                        rx_valid;
		logic [PIN_COUNT-1:0]        pin_out;
		logic [PIN_COUNT-1:0]        pin_oe;
		logic [PIN_COUNT*ROLE_W-1:0] pin_role;
		logic [PIN_COUNT-1:0]        gpio_in;
	} port_state_s;

	typedef struct packed {
		logic [7:0] dac_mask;
		logic [7:0] adc_mask;
		logic [7:0] gpo_mask;
		logic [7:0] gpi_mask;
		logic [7:0] gpo_data;
		logic       busy_en;
	} cfg_state_s;

	port_state_s                 st_reg;
	port_state_s                 st_next;
	cfg_state_s                  cfg_reg;
	cfg_state_s                  cfg_next;
	logic                        cfg_rst;
	logic                        sclk_fall;
	logic                        sclk_rise;
	logic                        sync_fall;
	logic [WORD_W-1:0]           word;
	logic                        word_done;
	logic                        ctl_we;
	logic [3:0]                  ctl_addr;
	logic [7:0]                  ctl_data;
	logic [PIN_COUNT-1:0]        mux_drive;
	logic [PIN_COUNT-1:0]        mux_oe;
	logic [PIN_COUNT-1:0]        mux_din;
	logic [PIN_COUNT*ROLE_W-1:0] mux_role;

	stream_if #(.WIDTH(WORD_W)) push_if ();
	stream_if #(.WIDTH(WORD_W)) pop_if ();
	pin_cfg_if                  cfg_if ();

	////////////////////////////////////////////////////////////////////////////
	// Configuration falls back to defaults whenever the reset pin is low
	assign cfg_rst = I_RST | ~I_DEV_RESET_N; // R8

	// Edges are seen on the second and third stages only
	assign sclk_fall = st_reg.sclk_s3 & ~st_reg.sclk_s2;
	assign sclk_rise = ~st_reg.sclk_s3 & st_reg.sclk_s2;
	assign sync_fall = st_reg.sync_s3 & ~st_reg.sync_s2;
	assign word      = {st_reg.rx_shift[WORD_W-2:0], st_reg.sdi_s2};
	assign word_done = (st_reg.fstate == ST_SHIFT) && !st_reg.sync_s2 && sclk_fall
		&& (st_reg.bit_idx == LAST_BIT_IDX);
	assign ctl_we    = word_done && !word[DAC_FLAG_BIT]; // R3
	assign ctl_addr  = word[ADDR_MSB:ADDR_LSB];
	assign ctl_data  = word[DATA_MSB:0];

	assign push_if.valid  = st_reg.push_req;
	assign push_if.data   = st_reg.push_data;
	assign pop_if.ready   = !st_reg.rx_valid || I_RX_READY;

	assign cfg_if.dac_mask = cfg_reg.dac_mask;
	assign cfg_if.adc_mask = cfg_reg.adc_mask;
	assign cfg_if.gpo_mask = cfg_reg.gpo_mask;
	assign cfg_if.gpi_mask = cfg_reg.gpi_mask;
	assign cfg_if.gpo_data = cfg_reg.gpo_data;
	assign cfg_if.busy_en  = cfg_reg.busy_en;

	////////////////////////////////////////////////////////////////////////////
	// Frame engine
	always_comb begin
		st_next          = st_reg;
		st_next.sclk_s1  = I_SCLK;
		st_next.sclk_s2  = st_reg.sclk_s1;
		st_next.sclk_s3  = st_reg.sclk_s2;
		st_next.sync_s1  = I_SYNC_N;
		st_next.sync_s2  = st_reg.sync_s1;
		st_next.sync_s3  = st_reg.sync_s2;
		st_next.sdi_s1   = I_SDI;
		st_next.sdi_s2   = st_reg.sdi_s1;
		st_next.pin_s1   = I_PIN_IN;
		st_next.pin_s2   = st_reg.pin_s1;
		st_next.tx_taken = 1'b0;
		st_next.push_req = 1'b0;
		st_next.drop     = st_reg.push_req & ~push_if.ready;
		unique case (st_reg.fstate)
			ST_IDLE: begin
				if (sync_fall) begin
					st_next.fstate   = ST_SHIFT; // R2
					st_next.bit_idx  = BIT_IDX_RESET;
					st_next.fell     = 1'b0;
					st_next.tx_shift = I_TX_DATA; // R6
					st_next.serial_output      = I_TX_DATA[WORD_W-1]; // R4
					st_next.sdo_oe   = 1'b1;
					st_next.tx_taken = 1'b1;
				end
			end
			ST_SHIFT: begin
				if (st_reg.sync_s2) begin
					st_next.fstate = ST_IDLE;
					st_next.sdo_oe = 1'b0;
				end else if (sclk_fall) begin
					st_next.rx_shift = word; // R1
					st_next.bit_idx  = st_reg.bit_idx + 1'b1;
					st_next.fell     = 1'b1;
					if (word_done) begin
						st_next.fstate = ST_DONE; // R2
						if (word[DAC_FLAG_BIT]) begin
							st_next.push_req  = 1'b1; // R3
							st_next.push_data = word;
						end
					end
				end else if (sclk_rise && st_reg.fell) begin
					st_next.tx_shift = {st_reg.tx_shift[WORD_W-2:0], 1'b0}; // R5
					st_next.serial_output      = st_reg.tx_shift[WORD_W-2];
					st_next.fell     = 1'b0;
				end
			end
			ST_DONE: begin
				if (st_reg.sync_s2) begin
					st_next.fstate = ST_IDLE;
					st_next.sdo_oe = 1'b0;
				end else if (sclk_rise && st_reg.fell) begin
					st_next.serial_output  = 1'b0; // R5
					st_next.fell = 1'b0;
				end
			end
			default: begin
				st_next.fstate = ST_IDLE;
				st_next.sdo_oe = 1'b0;
			end
		endcase
		if (pop_if.valid && pop_if.ready) begin
			st_next.rx_data  = pop_if.data;
			st_next.rx_valid = 1'b1;
		end else if (I_RX_READY) begin
			st_next.rx_valid = 1'b0;
		end
		st_next.pin_out  = mux_drive;
		st_next.pin_oe   = mux_oe;
		st_next.pin_role = mux_role;
		st_next.gpio_in  = mux_din;
	end

	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			st_reg <= '{fstate: ST_IDLE, sclk_s1: 1'b0, sclk_s2: 1'b0, sclk_s3: 1'b0,
				sync_s1: 1'b1, sync_s2: 1'b1, sync_s3: 1'b1, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control words update the pin configuration
	always_comb begin
		cfg_next = cfg_reg;
		if (ctl_we) begin
			unique case (ctl_addr)
				ADDR_DAC_CFG:  cfg_next.dac_mask = ctl_data; // R9
				ADDR_ADC_CFG:  cfg_next.adc_mask = ctl_data; // R9
				ADDR_GPO_CFG:  cfg_next.gpo_mask = ctl_data; // R9
				ADDR_GPI_CFG:  cfg_next.gpi_mask = ctl_data; // R9
				ADDR_GPO_DATA: cfg_next.gpo_data = ctl_data;
				ADDR_BUSY_CFG: cfg_next.busy_en  = ctl_data[BUSY_EN_BIT]; // R10
				default:       cfg_next = cfg_reg;
			endcase
		end
	end

	always_ff @(posedge I_SYS_CLK or posedge cfg_rst) begin
		if (cfg_rst) begin
			cfg_reg <= '{dac_mask: MASK_RESET, adc_mask: MASK_RESET, gpo_mask: MASK_RESET,
				gpi_mask: MASK_RESET, gpo_data: MASK_RESET, busy_en: 1'b0}; // R8
		end else begin
			cfg_reg <= cfg_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Submodules
	stream_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk (I_SYS_CLK),
		.rst (I_RST),
		.wr  (push_if),
		.rd  (pop_if)
	);

	pin_mux u_pin_mux (
		.cfg     (cfg_if),
		.i_busy  (I_ADC_BUSY),
		.i_pin   (st_reg.pin_s2),
		.o_drive (mux_drive),
		.o_oe    (mux_oe),
		.o_din   (mux_din),
		.o_role  (mux_role)
	);

	assign O_SDO      = st_reg.serial_output;
	assign O_SDO_OE   = st_reg.sdo_oe;
	assign O_TX_TAKEN = st_reg.tx_taken;
	assign O_RX_DATA  = st_reg.rx_data;
	assign O_RX_VALID = st_reg.rx_valid;
	assign O_RX_DROP  = st_reg.drop;
	assign O_PIN_OUT  = st_reg.pin_out;
	assign O_PIN_OE   = st_reg.pin_oe;
	assign O_PIN_ROLE = st_reg.pin_role;
	assign O_GPIO_IN  = st_reg.gpio_in;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	sdi_capture_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // R1
		(st_reg.fstate == ST_SHIFT && sclk_fall && !st_reg.sync_s2)
		|=> (st_reg.rx_shift[0] == $past(st_reg.sdi_s2)))
		else $error("serial input bit not captured on falling edge");
	frame_open_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // R2
		(st_reg.fstate == ST_IDLE && sync_fall)
		|=> (st_reg.fstate == ST_SHIFT && st_reg.bit_idx == BIT_IDX_RESET))
		else $error("frame did not open on select fall");
	frame_len_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // R2
		word_done |=> (st_reg.fstate == ST_DONE))
		else $error("frame did not close after sixteen bits");
	dac_push_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // R3
		(word_done && word[DAC_FLAG_BIT])
		|=> (st_reg.push_req && st_reg.push_data == $past(word)))
		else $error("DAC word not forwarded");
	msb_first_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // R4
		(st_reg.fstate == ST_IDLE && sync_fall)
		|=> (st_reg.serial_output == $past(I_TX_DATA[WORD_W-1]) && st_reg.sdo_oe))
		else $error("MSB not presented at frame open");
	shift_out_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // R5
		(st_reg.fstate == ST_SHIFT && !st_reg.sync_s2 && !sclk_fall && sclk_rise
		&& st_reg.fell) |=> (st_reg.serial_output == $past(st_reg.tx_shift[WORD_W-2])))
		else $error("next output bit not shifted on rise");
	hold_out_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // R5
		(st_reg.fstate == ST_SHIFT && !st_reg.sync_s2 && sclk_rise && !st_reg.fell)
		|=> $stable(st_reg.serial_output))
		else $error("output shifted on rise without a prior fall");
	cfg_default_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // R8
		!I_DEV_RESET_N |-> (cfg_reg.busy_en == 1'b0 && cfg_reg.dac_mask == MASK_RESET
		&& cfg_reg.gpo_mask == MASK_RESET))
		else $error("configuration not at default under reset pin");
	busy_pin_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST) // R10
		(cfg_reg.busy_en && $stable(cfg_reg.busy_en))
		|=> (st_reg.pin_oe[BUSY_PIN] && st_reg.pin_out[BUSY_PIN] == $past(I_ADC_BUSY)))
		else $error("pin seven does not follow busy");
endmodule : serial_port_top

`default_nettype wire

// >>> rtl/serial_port_pkg.sv
// What this block does
// R1 - Sample serial_input on serial-clock falling edges
// R2 - Frame select low opens frame of 16 falls
// R3 - Input frames carry DAC and control data
// R4 - Output MSB appears when frame select falls
// R5 - Next bit on first rise after fall
// R6 - Output stream carries results, read-back, temperature
// R7 - Host limits serial clock to 50/20 MHz
// R8 - Reset pin low restores default configuration asynchronously
// R9 - Each configurable_pin takes role from configuration
// R10 - configurable_pin_seven can show conversion busy
// R11 - Host holds select for 16 clocks
`default_nettype none

package serial_port_pkg;

	localparam int              WORD_W        = 16;
	localparam int              FIFO_DEPTH    = 32;
	localparam int              PIN_COUNT     = 8;
	localparam int              ROLE_W        = 3;
	localparam int              BUSY_PIN      = 7;
	localparam logic [3:0]      LAST_BIT_IDX  = 4'hF;
	localparam logic [3:0]      BIT_IDX_RESET = 4'h0;
	localparam int              DAC_FLAG_BIT  = 15;
	localparam int              ADDR_MSB      = 14;
	localparam int              ADDR_LSB      = 11;
	localparam int              DATA_MSB      = 7;
	localparam int              BUSY_EN_BIT   = 0;
	localparam logic [3:0]      ADDR_BUSY_CFG = 4'h3;
	localparam logic [3:0]      ADDR_ADC_CFG  = 4'h4;
	localparam logic [3:0]      ADDR_DAC_CFG  = 4'h5;
	localparam logic [3:0]      ADDR_GPO_CFG  = 4'h8;
	localparam logic [3:0]      ADDR_GPO_DATA = 4'h9;
	localparam logic [3:0]      ADDR_GPI_CFG  = 4'hA;
	localparam logic [7:0]      MASK_RESET    = 8'h00;
	localparam int              SCLK_PERIOD_NS = 320;
	localparam int              SYS_PERIOD_NS  = 40;

	typedef enum logic [2:0] {
		ROLE_NONE = 3'b000,
		ROLE_DAC  = 3'b001,
		ROLE_ADC  = 3'b010,
		ROLE_DIN  = 3'b011,
		ROLE_DOUT = 3'b100,
		ROLE_BUSY = 3'b101
	} pin_role_e;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SHIFT = 2'b01,
		ST_DONE  = 2'b10
	} frame_state_e;

endpackage

`default_nettype wire

// >>> rtl/serial_port_if.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Valid/ready word stream
interface stream_if #(parameter int WIDTH = 16);
	logic [WIDTH-1:0] data;
	logic             valid;
	logic             ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : stream_if

////////////////////////////////////////////////////////////////////////////////
// Pin configuration handed to the pin multiplexer
interface pin_cfg_if;
	logic [7:0] dac_mask;
	logic [7:0] adc_mask;
	logic [7:0] gpo_mask;
	logic [7:0] gpi_mask;
	logic [7:0] gpo_data;
	logic       busy_en;
	modport ctrl (output dac_mask, output adc_mask, output gpo_mask, output gpi_mask,
		output gpo_data, output busy_en);
	modport mux (input dac_mask, input adc_mask, input gpo_mask, input gpi_mask,
		input gpo_data, input busy_en);
endinterface : pin_cfg_if

`default_nettype wire

// >>> rtl/stream_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module stream_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Streams
	stream_if.snk    wr,
	stream_if.src    rd
);
	localparam int         PW         = $clog2(DEPTH);
	localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
	localparam logic [PW:0] ONE_COUNT  = (PW+1)'(1);

	typedef struct packed {
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [PW:0]   count;
	} fifo_state_s;

	fifo_state_s      st_reg;
	fifo_state_s      st_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             pop;

	assign wr.ready = (st_reg.count != FULL_COUNT);
	assign rd.valid = (st_reg.count != '0);
	assign rd.data  = mem[st_reg.rd_ptr];
	assign push     = wr.valid & wr.ready;
	assign pop      = rd.valid & rd.ready;

	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
		end
		if (pop) begin
			st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			st_next.count = st_reg.count + ONE_COUNT;
		end else if (pop && !push) begin
			st_next.count = st_reg.count - ONE_COUNT;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[st_reg.wr_ptr] <= wr.data;
		end
	end

	fifo_full_a: assert property (@(posedge clk) disable iff (rst)
		(st_reg.count == FULL_COUNT && wr.valid && !rd.ready) |=> (st_reg.count == FULL_COUNT))
		else $error("fifo accepts a word while full");
	fifo_count_a: assert property (@(posedge clk) disable iff (rst)
		(push && !pop) |=> (st_reg.count == $past(st_reg.count) + ONE_COUNT))
		else $error("fifo count did not grow on push");
endmodule : stream_fifo

`default_nettype wire

// >>> rtl/pin_mux.sv
`timescale 1ns/1ps
`default_nettype none

module pin_mux
	import serial_port_pkg::*;
(
	// Configuration
	pin_cfg_if.mux                         cfg,
	// Converter status and pin levels
	input  wire logic                      i_busy,
	input  wire logic [PIN_COUNT-1:0]      i_pin,
	// Pin drive and roles
	output logic      [PIN_COUNT-1:0]      o_drive,
	output logic      [PIN_COUNT-1:0]      o_oe,
	output logic      [PIN_COUNT-1:0]      o_din,
	output logic      [PIN_COUNT*ROLE_W-1:0] o_role
);
	// Busy on pin seven outranks every other role
	function automatic pin_role_e pick_role(input logic busy, input logic dac,
		input logic adc, input logic dout, input logic din);
		pin_role_e r;
		r = ROLE_NONE;
		if (busy) begin
			r = ROLE_BUSY;
		end else if (dac) begin
			r = ROLE_DAC;
		end else if (adc) begin
			r = ROLE_ADC;
		end else if (dout) begin
			r = ROLE_DOUT;
		end else if (din) begin
			r = ROLE_DIN;
		end
		return r;
	endfunction

	for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
		pin_role_e role;
		assign role = pick_role(cfg.busy_en && (i == BUSY_PIN), cfg.dac_mask[i],
			cfg.adc_mask[i], cfg.gpo_mask[i], cfg.gpi_mask[i]); // R9 R10
		assign o_role[i*ROLE_W +: ROLE_W] = role;
		assign o_oe[i]    = (role == ROLE_DOUT) || (role == ROLE_BUSY);
		assign o_drive[i] = (role == ROLE_BUSY) ? i_busy
			: ((role == ROLE_DOUT) & cfg.gpo_data[i]); // R10
		assign o_din[i]   = (role == ROLE_DIN) & i_pin[i];
	end
endmodule : pin_mux

`default_nettype wire

// >>> bench/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
	// Serial link to the device
	output logic      o_sclk,
	output logic      o_sync_n,
	output logic      o_sdi,
	input  wire logic i_sdo,
	input  wire logic i_sdo_oe
);

	initial begin
		o_sclk = 1'b0;
		o_sync_n = 1'b1;
		o_sdi = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One frame of n clocks at 320 ns; the clock stands still between frames
	task automatic frame(input logic [15:0] w, input int n, input logic idle_hi,
		output logic [15:0] rd, output logic first_bit, output logic oe_seen);
		int k;
		o_sclk = idle_hi;
		#200;
		o_sync_n = 1'b0;
		#200;
		first_bit = i_sdo;
		oe_seen = i_sdo_oe;
		rd = '0;
		for (k = 0; k < n; k++) begin
			// Data changes on the rise, well away from the sampling fall
			o_sclk = 1'b1;
			o_sdi = (k < 16) ? w[15-k] : ~o_sdi;
			#240;
			if (k < 16) rd[15-k] = i_sdo;
			o_sclk = 1'b0;
			#80;
		end
		if (idle_hi) begin
			o_sclk = 1'b1;
			#80;
		end
		o_sync_n = 1'b1;
		// Released line shows the inverse of its last level
		o_sdi = ~o_sdi;
		#240;
	endtask

endmodule // spi_host_model

`default_nettype wire

// >>> bench/config_adc_dac_serial_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module config_adc_dac_serial_port_tb_top
	import serial_port_pkg::*;
;

	logic                        sys_clk     = 1'b0;
	logic                        rst         = 1'b1;
	logic                        dev_reset_n = 1'b1;
	logic                        rx_ready    = 1'b0;
	logic                        adc_busy    = 1'b0;
	logic [WORD_W-1:0]           tx_data     = 16'h0000;
	logic [PIN_COUNT-1:0]        pin_in      = 8'h00;
	logic                        sclk, sync_n, serial_input, serial_output, sdo_oe, tx_taken, rx_valid, rx_drop;
	logic [WORD_W-1:0]           rx_data;
	logic [PIN_COUNT-1:0]        pin_out, pin_oe, gpio_in;
	logic [PIN_COUNT*ROLE_W-1:0] pin_role;
	logic [WORD_W-1:0]           rd;
	logic                        first_bit, oe_seen;
	int                          num_errors = 0;
	int                          checked    = 0;
	int                          drops      = 0;
	int                          takes      = 0;

	always #20 sys_clk = ~sys_clk;

	serial_port_top dut (
		.I_SYS_CLK(sys_clk), .I_RST(rst), .I_DEV_RESET_N(dev_reset_n),
		.I_SCLK(sclk), .I_SYNC_N(sync_n), .I_SDI(serial_input), .O_SDO(serial_output), .O_SDO_OE(sdo_oe),
		.I_TX_DATA(tx_data), .O_TX_TAKEN(tx_taken),
		.O_RX_DATA(rx_data), .O_RX_VALID(rx_valid), .I_RX_READY(rx_ready), .O_RX_DROP(rx_drop),
		.I_ADC_BUSY(adc_busy), .I_PIN_IN(pin_in), .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe),
		.O_PIN_ROLE(pin_role), .O_GPIO_IN(gpio_in)
	);

	spi_host_model host (
		.o_sclk(sclk), .o_sync_n(sync_n), .o_sdi(serial_input), .i_sdo(serial_output), .i_sdo_oe(sdo_oe)
	);

	always @(negedge sys_clk) begin
		if (rx_drop === 1'b1) drops++;
		if (tx_taken === 1'b1) takes++;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Common tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		if (num_errors == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic xfer(input logic [15:0] w, input int n, input logic idle_hi);
		host.frame(w, n, idle_hi, rd, first_bit, oe_seen);
		@(negedge sys_clk);
	endtask

	task automatic ctl(input logic [3:0] addr, input logic [7:0] data);
		xfer({1'b0, addr, 3'h0, data}, 16, 1'b0);
	endtask

	function automatic logic [15:0] dac_word(input int i);
		return 16'h8000 | 16'(i * 16'h0257);
	endfunction

	task automatic pop(input logic [15:0] exp);
		int t;
		t = 0;
		while (rx_valid !== 1'b1 && t < 200) begin
			@(negedge sys_clk);
			t++;
		end
		chk(rx_valid, 1);
		chk(rx_data, exp);
		rx_ready = 1'b1;
		@(negedge sys_clk);
		rx_ready = 1'b0;
		// Sink stalls between words
		repeat (3) @(negedge sys_clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic sc_reset();
		chk(sdo_oe, 0);
		chk(rx_valid, 0);
		chk(pin_oe, 0);
		chk(pin_role, 0);
		chk(gpio_in, 0);
	endtask

	task automatic sc_readback();
		int t0;
		for (int idle = 0; idle < 2; idle++) begin
			tx_data = idle ? 16'hA5C3 : 16'h5A3C;
			t0 = takes;
			// Control word to an unused address is ignored
			xfer(16'h0000, 16, 1'(idle));
			chk(first_bit, tx_data[15]);
			chk(oe_seen, 1);
			chk(rd, tx_data);
			chk(takes - t0, 1);
			chk(sdo_oe, 0);
			chk(rx_valid, 0);
		end
	endtask

	task automatic sc_pins();
		pin_in = 8'h40;
		ctl(ADDR_DAC_CFG, 8'h03);
		ctl(ADDR_ADC_CFG, 8'h0C);
		ctl(ADDR_GPO_CFG, 8'h30);
		ctl(ADDR_GPO_DATA, 8'h10);
		ctl(ADDR_GPI_CFG, 8'hC0);
		ctl(ADDR_BUSY_CFG, 8'h01);
		repeat (4) @(negedge sys_clk);
		chk(pin_role, {ROLE_BUSY, ROLE_DIN, ROLE_DOUT, ROLE_DOUT,
			ROLE_ADC, ROLE_ADC, ROLE_DAC, ROLE_DAC});
		chk(pin_oe[6:4], 3'b011);
		chk(pin_out[5:4], 2'b01);
		chk(gpio_in, 8'h40);
		chk(pin_oe[7], 1);
		adc_busy = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk(pin_out[7], 1);
		adc_busy = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk(pin_out[7], 0);
		dev_reset_n = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk(pin_role, 0);
		chk(pin_oe, 0);
		dev_reset_n = 1'b1;
		@(negedge sys_clk);
	endtask

	task automatic sc_dac();
		// The output register holds one word beyond the FIFO depth
		for (int i = 0; i <= FIFO_DEPTH + 1; i++) begin
			// Partial frame is discarded
			if (i == 16) xfer(16'hFFFF, 8, 1'b0);
			xfer(dac_word(i), (i == 0) ? 20 : 16, 1'(i % 2));
		end
		chk(drops, 1);
		for (int i = 0; i <= FIFO_DEPTH; i++) pop(dac_word(i));
		chk(rx_valid, 0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial begin
		repeat (16) @(negedge sys_clk);
		rst = 1'b0;
		repeat (2) @(negedge sys_clk);
		sc_reset();
		sc_readback();
		sc_pins();
		sc_dac();
		end_sim();
	end

	initial begin
		#1000000;
		num_errors++;
		end_sim();
	end

endmodule // config_adc_dac_serial_port_tb_top

`default_nettype wire
